// File: src/nmior_regs.svh
// Register offsets, field positions and timing counts of the network mode I/O router.
`ifndef NMIOR_REGS_SVH
`define NMIOR_REGS_SVH
// Register offsets on the plain register port.
`define NMIOR_CTRL_OFS 4'h0
`define NMIOR_STATUS_OFS 4'h4
`define NMIOR_IRQ_STAT_OFS 4'h8
`define NMIOR_IRQ_MASK_OFS 4'hC
// Control word fields.
`define NMIOR_CTRL_DRV_EN 0
`define NMIOR_CTRL_MODE_LO 12
`define NMIOR_CTRL_MODE_HI 14
`define NMIOR_CTRL_MODE_D 15
`define NMIOR_CTRL_FAULT_POL 16
`define NMIOR_CTRL_RESET 32'h0000_0000
// Status word fields.
`define NMIOR_ST_ENC_ERR 0
`define NMIOR_ST_EN_PIN 7
`define NMIOR_ST_DRV_EN 12
`define NMIOR_ST_DIR_PIN 14
// Interrupt status bits.
`define NMIOR_IRQ_INDEX 0
`define NMIOR_IRQ_ENC_ERR 1
`define NMIOR_IRQ_W 2
// Operating mode codes.
`define NMIOR_MODE_SINGLE 3'h0
`define NMIOR_MODE_DUAL 3'h1
// Timing: clock period and marker pulse, in nanoseconds.
`define NMIOR_CLK_NS 20
`define NMIOR_MARK_PERIOD_NS 51200
`define NMIOR_MARK_WIDTH_NS 800
`define NMIOR_MARK_PERIOD_CYC (`NMIOR_MARK_PERIOD_NS / `NMIOR_CLK_NS)
`define NMIOR_MARK_WIDTH_CYC ((`NMIOR_MARK_WIDTH_NS + `NMIOR_CLK_NS - 1) / `NMIOR_CLK_NS)
`define NMIOR_CNT_W 12
`endif

// File: src/nmior_pkg.sv
// Types shared by the network mode I/O router.
package nmior_pkg;
  // Connector inputs sampled on ref_clk.
  typedef struct packed {
    logic amplifier_enable_pin;  // Enable pin, low means encoder error in dual loop.
    logic direction_pin;         // Direction pin, master phase A.
    logic step_pin;              // Step pin, master phase B.
    logic fault_condition;       // Drive fault present.
  } nmior_pins_t;
  // Routed outputs toward the capture logic and the connector.
  typedef struct packed {
    logic master_phase_a_capture;       // Master encoder phase A.
    logic master_phase_b_capture;       // Master encoder phase B.
    logic master_latch_strobe_capture;  // Master encoder latch strobe.
    logic master_encoder_error;         // Master encoder error level.
    logic fault_pin;                    // Fault output level.
  } nmior_outs_t;
  // Decoded operating mode.
  typedef enum logic [1:0] {
    NMIOR_NET_SINGLE,
    NMIOR_NET_DUAL,
    NMIOR_OTHER
  } nmior_mode_t;
endpackage

// File: src/nmior.sv
// Network mode I/O router: connector routing, fault output and marker pulse.
`timescale 1ns/1ns
//
// The router sits between the controller connector and the servo core. In the
// two network modes it hands the direction and step pins to the master counter,
// the enable pin to the latch strobe, and shapes the fault output. In every
// other mode the routes rest at zero and the fault pin shows its plain level.
//
// Every output leaves through one register stage, so each pin level and each
// read answer appears exactly one clock after the input or strobe behind it.
// Software sees the block through four 32-bit words: control, status, event
// status and event mask. Events are sticky; a read of the event word clears
// them, but an event that lands in the very cycle of that read survives it, so
// no edge is ever lost between two polls.
//
// The marker timer runs free from reset. Its window forces the fault pin low
// for a short burst once per period whenever the pulse is wanted; the master
// encoder interface keys on that burst to align itself with the servo cycle.
//
// Limitation: the enable pin is taken as already synchronous to ref_clk. A pin
// that comes straight off the connector needs a synchroniser in front.
`include "nmior_regs.svh"

module nmior (
  input  wire logic                   ref_clk,
  input  wire logic                   srst,
  input  wire logic [3:0]             addr,
  input  wire logic [31:0]            wr_data,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  input  wire nmior_pkg::nmior_pins_t pins_in,
  output      logic [31:0]            rd_data_r,
  output      nmior_pkg::nmior_outs_t pins_out_r,
  output      logic                   irq_r
);
  import nmior_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Control state. Only these words and the marker timer carry state; the
  // routes themselves are pure decode, so a mode change takes effect on the
  // very next clock without any flush or reset.

  logic [31:0]              ctrl_r;        // Control word.
  logic [`NMIOR_IRQ_W-1:0]  irq_stat_r;    // Sticky event bits.
  logic [`NMIOR_IRQ_W-1:0]  irq_stat_nxt;  // Next sticky event bits.
  logic [`NMIOR_IRQ_W-1:0]  irq_mask_r;    // Interrupt enables.
  logic [`NMIOR_CNT_W-1:0]  mark_cnt_r;    // Marker period counter.
  logic                     en_pin_r;      // Enable pin of the last cycle.
  logic                     mark_r;        // Marker window active.

  ////////////////////////////////////////////////////////////////////////////
  // Mode and control decode. Any mode code other than the two network codes
  // parks the router; it never guesses at the meaning of a reserved code.

  wire [2:0]   mode_field   = ctrl_r[`NMIOR_CTRL_MODE_HI:`NMIOR_CTRL_MODE_LO];
  wire         mode_bit_d_a = ctrl_r[`NMIOR_CTRL_MODE_D];
  wire         fault_polarity_select = ctrl_r[`NMIOR_CTRL_FAULT_POL];
  wire         power_driver_enable_flag = ctrl_r[`NMIOR_CTRL_DRV_EN];
  // Decode straight from the live control word each cycle.
  wire nmior_mode_t mode =
    (mode_field == `NMIOR_MODE_SINGLE) ? NMIOR_NET_SINGLE :
    (mode_field == `NMIOR_MODE_DUAL)   ? NMIOR_NET_DUAL : NMIOR_OTHER;
  wire         net_mode  = (mode != NMIOR_OTHER);
  wire         is_single = (mode == NMIOR_NET_SINGLE);
  wire         is_dual   = (mode == NMIOR_NET_DUAL);

  ////////////////////////////////////////////////////////////////////////////
  // Fault output decode. The two polarities are not mirror images: with the
  // polarity bit clear a disabled drive shows high, with it set a disabled
  // drive shows low. Both are kept as separate terms so neither is derived
  // from the other by a plain inversion.

  wire drv_on   = power_driver_enable_flag;
  wire fault_in = pins_in.fault_condition;
  // Polarity clear: the pin falls only for an enabled, faulted drive.
  wire fault_lvl_pos = ~(drv_on & fault_in);
  // Polarity set: the pin rises only for an enabled, healthy drive.
  wire fault_lvl_neg = drv_on & ~fault_in;
  wire fault_base = fault_polarity_select ? fault_lvl_neg : fault_lvl_pos;
  // Single loop with D set turns the pin into a slave enable.
  wire pulse_on   = net_mode & ~(is_single & mode_bit_d_a);
  // The marker forces the pin low; the encoder interface keys on that edge.
  wire fault_nxt  = (pulse_on & mark_r) ? 1'b0 : fault_base;

  ////////////////////////////////////////////////////////////////////////////
  // Connector routing. Outside the network modes the routes are held idle.
  // Holding them at zero, rather than passing the pins through, keeps stray
  // pin activity in other modes from clocking the master counter.
  // The latch strobe follows the enable pin in both modes; in dual loop it
  // therefore also sees the index pulse and captures on it.

  wire en_pin = pins_in.amplifier_enable_pin;
  nmior_outs_t outs_nxt;
  assign outs_nxt.master_latch_strobe_capture = net_mode & en_pin;
  assign outs_nxt.master_phase_a_capture = net_mode & pins_in.direction_pin;
  assign outs_nxt.master_phase_b_capture = net_mode & pins_in.step_pin;
  assign outs_nxt.master_encoder_error   = is_dual & ~en_pin;
  assign outs_nxt.fault_pin              = fault_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Events. The index arrives as a short pulse on the enable pin; its rising
  // edge is the index. An error is the enable pin falling in dual loop.
  // The pulse starts with a fall, so each index also records an error onset;
  // software tells the two apart by the pin level in the status word.

  wire idx_evt = is_dual & en_pin & ~en_pin_r;
  wire err_evt = is_dual & ~en_pin & en_pin_r;
  wire [`NMIOR_IRQ_W-1:0] evt = {err_evt, idx_evt};

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode. Addresses are matched in full; a write to the status
  // word or to an unmapped address is simply dropped.

  wire wr_ctrl   = wr_en & (addr == `NMIOR_CTRL_OFS);
  wire wr_mask   = wr_en & (addr == `NMIOR_IRQ_MASK_OFS);
  wire rd_istat  = rd_en & (addr == `NMIOR_IRQ_STAT_OFS);
  // Input status word; bit 14 reads zero in the network modes.
  wire [31:0] status_word =
    (32'(power_driver_enable_flag) << `NMIOR_ST_DRV_EN) |
    (32'(en_pin) << `NMIOR_ST_EN_PIN) |
    (32'(~net_mode & pins_in.direction_pin) << `NMIOR_ST_DIR_PIN) |
    (32'(is_dual & ~en_pin) << `NMIOR_ST_ENC_ERR);
  // Read selection; an unmapped address reads as zero.
  wire [31:0] rd_mux =
    (addr == `NMIOR_CTRL_OFS)     ? ctrl_r :
    (addr == `NMIOR_STATUS_OFS)   ? status_word :
    (addr == `NMIOR_IRQ_STAT_OFS) ? 32'(irq_stat_r) :
    (addr == `NMIOR_IRQ_MASK_OFS) ? 32'(irq_mask_r) : 32'h0000_0000;
  // A new event in the clearing cycle survives the read.
  assign irq_stat_nxt = (irq_stat_r & ~{`NMIOR_IRQ_W{rd_istat}}) | evt;

  ////////////////////////////////////////////////////////////////////////////
  // Register file and read data, one cycle after the strobe.
  // The read data return to zero when no read is pending, so a stale answer
  // can never be mistaken for a fresh one.

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_r     <= `NMIOR_CTRL_RESET;
      irq_mask_r <= '0;
      irq_stat_r <= '0;
      rd_data_r  <= 32'h0000_0000;
      irq_r      <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wr_data;
      end
      if (wr_mask) begin
        irq_mask_r <= wr_data[`NMIOR_IRQ_W-1:0];
      end
      irq_stat_r <= irq_stat_nxt;
      // Unmapped addresses and idle cycles read as zero.
      rd_data_r  <= rd_en ? rd_mux : 32'h0000_0000;
      // The interrupt follows the next status, so it rises with the sticky bit.
      irq_r      <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Marker timer. It runs free so the pulse keeps its period across mode
  // changes; enabling the pulse mid-window may yield one short first pulse.
  // The window is rounded up to whole clocks so, after the first, it is never shorter than asked.
  // The first window after reset is one clock short, since the count starts at zero.

  wire mark_wrap = (mark_cnt_r == `NMIOR_CNT_W'(`NMIOR_MARK_PERIOD_CYC - 1));
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mark_cnt_r <= '0;
      mark_r     <= 1'b0;
    end else begin
      mark_cnt_r <= mark_wrap ? '0 : mark_cnt_r + 1'b1;
      mark_r     <= mark_wrap | (mark_cnt_r < `NMIOR_CNT_W'(`NMIOR_MARK_WIDTH_CYC - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs, registered once. The fault pin rests high in reset, which a
  // downstream monitor reads as no fault for a disabled drive.

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pins_out_r <= '{fault_pin: 1'b1, default: 1'b0};
      // The enable pin idles high, so the edge memory starts high as well;
      // otherwise the first clock after reset could see a false rising edge.
      en_pin_r   <= 1'b1;
    end else begin
      pins_out_r <= outs_nxt;
      en_pin_r   <= en_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks. Each property but mark_range_a looks one clock ahead, matching the single register
  // stage on every output; all are off while reset is held.

  idle_route_a: assert property (@(posedge ref_clk) disable iff (srst)
    !net_mode |=> !pins_out_r.master_latch_strobe_capture && !pins_out_r.master_phase_a_capture)
    else $error("Routes active outside network modes.");

  drv_status_a: assert property (@(posedge ref_clk) disable iff (srst)
    rd_en && addr == `NMIOR_STATUS_OFS |=> rd_data_r[`NMIOR_ST_DRV_EN] == $past(power_driver_enable_flag))
    else $error("Drive enable status wrong.");

  pin_status_a: assert property (@(posedge ref_clk) disable iff (srst)
    rd_en && addr == `NMIOR_STATUS_OFS && is_single |=> rd_data_r[`NMIOR_ST_EN_PIN] == $past(en_pin))
    else $error("Enable pin status wrong.");

  strobe_route_a: assert property (@(posedge ref_clk) disable iff (srst)
    net_mode |=> pins_out_r.master_latch_strobe_capture == $past(en_pin))
    else $error("Latch strobe not routed.");

  phase_route_a: assert property (@(posedge ref_clk) disable iff (srst)
    net_mode |=> pins_out_r.master_phase_a_capture == $past(pins_in.direction_pin) &&
      pins_out_r.master_phase_b_capture == $past(pins_in.step_pin))
    else $error("Phase routing wrong.");

  status_dir_a: assert property (@(posedge ref_clk) disable iff (srst)
    rd_en && addr == `NMIOR_STATUS_OFS && net_mode |=> !rd_data_r[`NMIOR_ST_DIR_PIN])
    else $error("Direction status bit set in a network mode.");

  fault_pos_a: assert property (@(posedge ref_clk) disable iff (srst)
    !fault_polarity_select && !(pulse_on && mark_r) |=> pins_out_r.fault_pin == !$past(drv_on && fault_in))
    else $error("Fault pin wrong, polarity clear.");

  fault_neg_a: assert property (@(posedge ref_clk) disable iff (srst)
    fault_polarity_select && !(pulse_on && mark_r) |=> pins_out_r.fault_pin == $past(drv_on && !fault_in))
    else $error("Fault pin wrong, polarity set.");

  marker_len_a: assert property (@(posedge ref_clk) disable iff (srst)
    mark_wrap |=> mark_r [*8] ##(`NMIOR_MARK_WIDTH_CYC - 8) mark_r ##1 !mark_r)
    else $error("Marker width wrong.");

  marker_pin_a: assert property (@(posedge ref_clk) disable iff (srst)
    pulse_on && mark_r |=> !pins_out_r.fault_pin)
    else $error("Marker not on fault pin.");

  no_marker_a: assert property (@(posedge ref_clk) disable iff (srst)
    is_single && mode_bit_d_a |=> pins_out_r.fault_pin == $past(fault_base))
    else $error("Marker inserted with D set.");

  enc_err_a: assert property (@(posedge ref_clk) disable iff (srst)
    is_dual |=> pins_out_r.master_encoder_error == !$past(en_pin))
    else $error("Encoder error level wrong.");

  index_evt_a: assert property (@(posedge ref_clk) disable iff (srst)
    is_dual && en_pin && !en_pin_r |=> irq_stat_r[`NMIOR_IRQ_INDEX])
    else $error("Index edge not recorded.");

  // Event and status checks for the dual loop, and idle routes elsewhere.
  err_evt_a: assert property (@(posedge ref_clk) disable iff (srst)
    is_dual && !en_pin && en_pin_r |=> irq_stat_r[`NMIOR_IRQ_ENC_ERR])
    else $error("Encoder error onset not recorded.");

  err_status_a: assert property (@(posedge ref_clk) disable iff (srst)
    rd_en && addr == `NMIOR_STATUS_OFS |=> rd_data_r[`NMIOR_ST_ENC_ERR] == $past(is_dual && !en_pin))
    else $error("Encoder error status wrong.");

  single_no_err_a: assert property (@(posedge ref_clk) disable iff (srst)
    !is_dual |=> !pins_out_r.master_encoder_error)
    else $error("Encoder error shown outside dual loop.");

  quiet_events_a: assert property (@(posedge ref_clk) disable iff (srst)
    !is_dual && !rd_istat |=> irq_stat_r == $past(irq_stat_r))
    else $error("Event recorded outside dual loop.");

  idle_phase_b_a: assert property (@(posedge ref_clk) disable iff (srst)
    !net_mode |=> !pins_out_r.master_phase_b_capture)
    else $error("Phase B route active outside network modes.");

  // Marker gating and timer range.
  marker_off_a: assert property (@(posedge ref_clk) disable iff (srst)
    !pulse_on |=> pins_out_r.fault_pin == $past(fault_base))
    else $error("Marker inserted while switched off.");

  mark_range_a: assert property (@(posedge ref_clk) disable iff (srst)
    mark_cnt_r <= `NMIOR_CNT_W'(`NMIOR_MARK_PERIOD_CYC - 1))
    else $error("Marker counter past its period.");

  // Register port behaviour: writes, idle read data, clearing and interrupt.
  ctrl_write_a: assert property (@(posedge ref_clk) disable iff (srst)
    wr_en && addr == `NMIOR_CTRL_OFS |=> ctrl_r == $past(wr_data))
    else $error("Control write lost.");

  read_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
    !rd_en |=> rd_data_r == 32'h0000_0000)
    else $error("Read data not idle.");

  stat_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    rd_istat |=> irq_stat_r == $past(evt))
    else $error("Event status not cleared by read.");

  irq_level_a: assert property (@(posedge ref_clk) disable iff (srst)
    1'b1 |=> irq_r == |(irq_stat_r & $past(irq_mask_r)))
    else $error("Interrupt level wrong.");

endmodule

// File: dv/nmior_partner.sv
// Encoder interface and fault source model that drives the router's connector pins.
`timescale 1ns/1ns
module nmior_partner (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              err_cmd,
  input  wire logic              index_cmd,
  input  wire logic              fault_cmd,
  input  wire logic              dir_cmd,
  input  wire logic              step_cmd,
  output nmior_pkg::nmior_pins_t pins
);
  import nmior_pkg::*;
  // An index pulse lasts 0.4 us, twenty cycles of 20 ns.
  localparam int IDX_CYC = 20;
  logic [4:0]  idx_r  = 5'h00;    // Cycles left of the index pulse.
  nmior_pins_t pins_r = 4'b1000;  // Enable pin idles high, so no error shows.
  assign pins = pins_r;
  // The pin drops for an error or an index pulse; its rising edge marks the index.
  always @(posedge ref_clk) begin
    if (srst) begin
      idx_r <= 5'h00;
      pins_r <= 4'b1000;
    end else begin
      idx_r <= index_cmd ? 5'(IDX_CYC) : idx_r - 5'(idx_r != 5'h00);
      pins_r <= {~err_cmd & (idx_r == 5'h00), dir_cmd, step_cmd, fault_cmd};
    end
  end
endmodule

// File: dv/network_mode_io_router_test.sv
// Self-checking bench of the network mode I/O router and its encoder partner.
`timescale 1ns/1ns
`include "nmior_regs.svh"
module network_mode_io_router_test;
  import nmior_pkg::*;
  // One expected result: name, value, compare mask, and pins or read data.
  typedef struct {string nm; logic [31:0] ex; logic [31:0] mk; bit pin;} nmior_note_t;
  localparam logic [3:0] a_ctl = `NMIOR_CTRL_OFS;
  localparam logic [3:0] a_st  = `NMIOR_STATUS_OFS;
  localparam logic [3:0] a_irq = `NMIOR_IRQ_STAT_OFS;
  localparam logic [3:0] a_msk = `NMIOR_IRQ_MASK_OFS;
  localparam logic [31:0] all_m = 32'hFFFF_FFFF;
  localparam logic [31:0] w = `NMIOR_MARK_WIDTH_CYC;
  logic ref_clk = 1'b0, srst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wr_data = 32'h0, seed = 32'h2859324E, r, v;
  logic err_cmd = 1'b0, index_cmd = 1'b0, fault_cmd = 1'b0, dir_cmd = 1'b0, step_cmd = 1'b0;
  logic snap = 1'b0, snap_d = 1'b0, rd_d = 1'b0, net;
  logic [2:0]  c, m;
  logic [31:0] mk_ctl [4] = '{32'h0, 32'h0000_9000, 32'h0000_8000, 32'h0000_2000};
  logic [31:0] mk_exp [4] = '{w, w, 32'h0, 32'h0};
  nmior_pins_t pins_in;
  nmior_outs_t pins_out_r;
  logic [31:0] rd_data_r;
  logic        irq_r;
  int fails = 0, num_checks = 0, cycles = 0, i, n;
  nmior_note_t q[$], nt;
  always #10 ref_clk = ~ref_clk;
  nmior DUT (.ref_clk(ref_clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .pins_in(pins_in), .rd_data_r(rd_data_r), .pins_out_r(pins_out_r), .irq_r(irq_r));
  nmior_partner enc (.ref_clk(ref_clk), .srst(srst), .err_cmd(err_cmd), .index_cmd(index_cmd),
    .fault_cmd(fault_cmd), .dir_cmd(dir_cmd), .step_cmd(step_cmd), .pins(pins_in));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Bus cycles hold every signal for one whole cycle, as the slave never stalls.
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] ex, logic [31:0] mk, string nm);
    q.push_back('{nm, ex, mk, 1'b0});
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
  endtask
  // Pins settle in two cycles: one through the partner, one through the router.
  task automatic pk(logic [5:0] ex, logic [5:0] mk, string nm);
    repeat (3) @(posedge ref_clk);
    q.push_back('{nm, 32'(ex), 32'(mk), 1'b1});
    snap <= 1'b1;
    @(posedge ref_clk);
    snap <= 1'b0;
  endtask
  // The wait covers the partner's twenty cycle index pulse.
  task automatic idx();
    index_cmd <= 1'b1;
    @(posedge ref_clk);
    index_cmd <= 1'b0;
    repeat (30) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // The watcher takes the oldest note when a read answer or a pin snapshot is due.
  always @(posedge ref_clk) begin
    rd_d <= rd_en;
    snap_d <= snap;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      stop_test();
    end
  end
  always @(negedge ref_clk) begin
    if (rd_d || snap_d) begin
      nt = q.pop_front();
      chk(nt.nm, nt.ex & nt.mk, (nt.pin ? {26'h0, irq_r, pins_out_r} : rd_data_r) & nt.mk);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    rd(a_ctl, `NMIOR_CTRL_RESET, all_m, "ctrl reset");
    rd(a_st, 32'h0000_0080, all_m, "status reset");
    rd(a_irq, 32'h0, all_m, "irq reset");
    r = xs();
    v = (r & 32'hFFFE_0FFE) | 32'h0000_8000;
    wr(a_ctl, v);
    wr(4'h2, all_m);
    wr(a_st, all_m);
    rd(a_ctl, v, all_m, "ctrl readback");
    rd(4'h2, 32'h0, all_m, "unmapped read");
    rd(a_st, 32'h0000_0080, 32'h0000_5081, "status locked");
    wr(a_ctl, v | 32'h1);
    rd(a_st, 32'h0000_1080, 32'h0000_5081, "drive enabled");
    // Every polarity, enable and fault combination, with the marker off.
    for (i = 0; i < 8; i++) begin
      c = 3'(i);
      fault_cmd <= c[0];
      wr(a_ctl, {15'h0, c[2], 4'h8, 11'h0, c[1]});
      pk({5'h0, c[2] ? (c[1] & ~c[0]) : ~(c[1] & c[0])}, 6'h01, "fault level");
    end
    // Modes change in flight with no reset; the marker bit is masked out.
    for (i = 0; i < 6; i++) begin
      r = xs();
      m = 3'(i % 3);
      net = (m < 3'h2);
      dir_cmd <= r[0];
      step_cmd <= r[1];
      wr(a_ctl, {16'h0, 1'b1, m, 12'h0});
      pk({1'b0, net & r[0], net & r[1], net, 2'b00}, 6'h3E, "routes");
      rd(a_st, {17'h0, ~net & r[0], 14'h0}, 32'h0000_4000, "dir status");
    end
    dir_cmd <= 1'b0;
    step_cmd <= 1'b0;
    wr(a_ctl, 32'h0000_1000);
    wr(a_msk, 32'h3);
    rd(a_msk, 32'h3, 32'h3, "irq mask");
    err_cmd <= 1'b1;
    pk(6'b100010, 6'h3E, "encoder error");
    rd(a_st, 32'h1, 32'h0000_0081, "error status");
    rd(a_irq, 32'h2, all_m, "error onset");
    rd(a_irq, 32'h0, all_m, "irq cleared");
    pk(6'b000010, 6'h3E, "irq dropped");
    err_cmd <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(a_irq, 32'h1, all_m, "error release");
    idx();
    rd(a_irq, 32'h3, all_m, "index event");
    wr(a_msk, 32'h0);
    idx();
    pk(6'b000100, 6'h3E, "masked index");
    rd(a_irq, 32'h3, all_m, "masked status");
    wr(a_ctl, 32'h0000_8000);
    err_cmd <= 1'b1;
    pk(6'b000000, 6'h3E, "single pin low");
    rd(a_st, 32'h0, 32'h0000_0081, "single status");
    err_cmd <= 1'b0;
    // Any whole period holds one full marker window when the pulse is on.
    for (i = 0; i < 4; i++) begin
      wr(a_ctl, mk_ctl[i]);
      repeat (4) @(posedge ref_clk);
      n = 0;
      repeat (`NMIOR_MARK_PERIOD_CYC) @(negedge ref_clk) n += int'(pins_out_r.fault_pin === 1'b0);
      chk("marker low cycles", mk_exp[i], 32'(n));
    end
    stop_test();
  end
endmodule
